// [lpt_chk.sv]
// checker: wire rules of the training set exchange
// assumes plain copies of the link interface signals on ref_clk
`timescale 1ns/1ps
module lpt_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // device sets
  input wire logic devTsValid,
  input wire logic devTsDeemph,
  input wire logic devTsHot,
  // partner sets
  input wire logic ptnTsValid,
  input wire logic ptnTsDeemph,
  input wire logic ptnTsHot
);
  logic [7:0] devHotCnt;
  logic [7:0] ptnHotCnt;

  default clocking ck @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // run length of each hot reset bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      devHotCnt <= 8'h00;
      ptnHotCnt <= 8'h00;
    end else begin
      devHotCnt <= devTsHot ? devHotCnt + 8'h01 : 8'h00;
      ptnHotCnt <= ptnTsHot ? ptnHotCnt + 8'h01 : 8'h00;
    end
  end

  a_rst_idle: assert property (
    $fell(sys_rst) |-> !devTsValid && !ptnTsValid)
    else $error("training sets sent at reset release");
  a_rst_deemph: assert property (
    $fell(sys_rst) |-> devTsDeemph && ptnTsDeemph)
    else $error("deemph not at gen1 level after reset");
  a_dev_hot_len: assert property (
    $fell(devTsHot) |-> devHotCnt == lpt_pkg::HOT_HOLD + 8'h01)
    else $error("device hot reset length wrong");
  a_ptn_hot_len: assert property (
    $fell(ptnTsHot) |-> ptnHotCnt == lpt_pkg::HOT_HOLD + 8'h01)
    else $error("partner hot reset length wrong");
  a_dev_reply: assert property (
    ptnTsValid && !devTsValid |-> ##[1:2] devTsValid)
    else $error("device ignored partner sets");
  a_ptn_reply: assert property (
    devTsValid && !ptnTsValid |-> ##[1:2] ptnTsValid)
    else $error("partner ignored device sets");
  a_dev_hot_set: assert property (
    devTsHot |-> devTsValid)
    else $error("device hot bit outside sets");
  a_ptn_hot_set: assert property (
    ptnTsHot |-> ptnTsValid)
    else $error("partner hot bit outside sets");
endmodule

// [lpt_device_end.sv]
// switch port link training control with an AHB-Lite register slave
// assumes synchronous inputs on ref_clk and a single bus master
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module lpt_device_end (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic      [1:0]  hresp,
  // link
  lpt_link_if.dev          link,
  // reset effects
  output logic             portHotReset,
  output logic             partHotReset,
  output logic             deemphApplied,
  output logic             linkUp
);
  lpt_pkg::lpt_state_t state;
  lpt_pkg::lpt_state_t next_state;
  logic       deemphSel;
  logic       xlinkDis;
  logic       speedInit;
  logic       portDown;
  logic       hotReq;
  logic [7:0] seed;
  logic       laneDown;
  logic       gen2;
  logic       xlink;
  logic       negDeemph;
  logic [7:0] holdCnt;
  logic       dataPh;
  logic       wrQ;
  logic [7:0] addrQ;
  logic       next_lane;
  logic       next_gen2;
  logic       next_xlink;
  logic       next_neg;
  logic       next_applied;
  logic       next_speed;

  // bus decode
  wire addrPh = hsel && hready && htrans == lpt_pkg::HTRANS_NONSEQ;
  wire wrLc2  = dataPh && wrQ && addrQ == lpt_pkg::OFS_LCTL2;
  wire wrCfg  = dataPh && wrQ && addrQ == lpt_pkg::OFS_PHYCFG;
  wire wrSeed = dataPh && wrQ && addrQ == lpt_pkg::OFS_SEED;
  wire [31:0] stsWord = {25'h000_0000, xlink, negDeemph, gen2,
                         state, laneDown};
  wire [31:0] rdMux =
    addrQ == lpt_pkg::OFS_LCTL2  ? {31'h0000_0000, deemphSel} :
    addrQ == lpt_pkg::OFS_PHYCFG ? {28'h000_0000, hotReq, portDown,
                                    speedInit, xlinkDis} :
    addrQ == lpt_pkg::OFS_SEED   ? {24'h00_0000, seed} :
    addrQ == lpt_pkg::OFS_STATUS ? stsWord : 32'h0000_0000;

  // link decode
  wire rxTs     = link.ptnTsValid;
  wire sameKind = link.ptnTsOrient == portDown;
  wire canHot   = portDown && laneDown;
  wire autoSpd  = portDown || (xlink && speedInit);
  wire hotDone  = holdCnt == lpt_pkg::HOT_HOLD;

  // bus slave: one wait state, read data taken after any write lands
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dataPh    <= 1'b0;
      wrQ       <= 1'b0;
      addrQ     <= 8'h00;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= lpt_pkg::HRESP_OKAY;
    end else begin
      dataPh    <= addrPh;
      hreadyout <= !addrPh;
      if (addrPh) begin
        wrQ   <= hwrite;
        addrQ <= haddr[7:0];
      end
      if (dataPh && !wrQ) begin
        hrdata <= rdMux;
      end
    end
  end

  // software registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      deemphSel <= lpt_pkg::RST_DSEL;
      xlinkDis  <= 1'b0;
      speedInit <= 1'b0;
      portDown  <= 1'b0;
      seed      <= lpt_pkg::RST_SEED;
    end else begin
      if (wrLc2) begin
        deemphSel <= hwdata[lpt_pkg::LC2_DSEL];
      end
      if (wrCfg) begin
        xlinkDis  <= hwdata[lpt_pkg::CFG_XDIS];
        speedInit <= hwdata[lpt_pkg::CFG_SPDI];
        portDown  <= hwdata[lpt_pkg::CFG_DOWN];
      end
      if (wrSeed) begin
        seed <= hwdata[7:0];
      end
    end
  end

  // hot reset request: a new write wins over the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hotReq <= 1'b0;
    end else if (wrCfg && hwdata[lpt_pkg::CFG_HOTRQ]) begin
      hotReq <= 1'b1;
    end else if (state == lpt_pkg::ST_HOTRST || !portDown) begin
      hotReq <= 1'b0;
    end
  end

  // training state decisions
  always_comb begin
    next_state   = state;
    next_lane    = laneDown;
    next_gen2    = gen2;
    next_xlink   = xlink;
    next_neg     = negDeemph;
    next_applied = deemphApplied;
    next_speed   = 1'b0;
    case (state)
      lpt_pkg::ST_DETECT: begin
        next_state = lpt_pkg::ST_TRAIN;
      end
      lpt_pkg::ST_TRAIN: begin
        if (rxTs && !link.ptnTsHot) begin
          next_gen2    = 1'b0;
          next_applied = lpt_pkg::DEEMPH_3P5;
          if (!sameKind) begin
            next_lane  = portDown;
            next_xlink = 1'b0;
            next_state = lpt_pkg::ST_L0;
          end else if (!xlinkDis &&
                       seed != link.ptnTsSeed) begin
            next_lane  = seed > link.ptnTsSeed;
            next_xlink = 1'b1;
            next_state = lpt_pkg::ST_L0;
          end
        end
      end
      lpt_pkg::ST_L0: begin
        if (rxTs && link.ptnTsHot) begin
          next_state = lpt_pkg::ST_HOTRST;
        end else if (rxTs || (hotReq && canHot)) begin
          next_state = lpt_pkg::ST_RECOV;
        end else if (!gen2 && autoSpd) begin
          next_speed = 1'b1;
          next_state = lpt_pkg::ST_RECOV;
        end
      end
      lpt_pkg::ST_RECOV: begin
        next_speed = link.devTsSpeed;
        if (rxTs && link.ptnTsHot) begin
          next_state = lpt_pkg::ST_HOTRST;
        end else if (rxTs && hotReq && canHot) begin
          next_state = lpt_pkg::ST_HOTRST;
        end else if (rxTs) begin
          next_gen2  = gen2 || link.devTsSpeed || link.ptnTsSpeed;
          // downstream port keeps its own, upstream port adopts
          next_neg   = portDown ? deemphSel
                                : link.ptnTsDeemph;
          next_applied = next_gen2 ? next_neg
                                   : lpt_pkg::DEEMPH_3P5;
          next_state = lpt_pkg::ST_L0;
        end
      end
      lpt_pkg::ST_HOTRST: begin
        if (hotDone) begin
          next_state = lpt_pkg::ST_DETECT;
        end
      end
      default: begin
        next_state = lpt_pkg::ST_DETECT;
      end
    endcase
  end

  // training state and link outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state            <= lpt_pkg::ST_DETECT;
      laneDown         <= 1'b0;
      gen2             <= 1'b0;
      xlink            <= 1'b0;
      negDeemph        <= lpt_pkg::DEEMPH_3P5;
      deemphApplied    <= lpt_pkg::DEEMPH_3P5;
      holdCnt          <= 8'h00;
      linkUp           <= 1'b0;
      portHotReset     <= 1'b0;
      partHotReset     <= 1'b0;
      link.devTsValid  <= 1'b0;
      link.devTsOrient <= 1'b0;
      link.devTsSeed   <= 8'h00;
      link.devTsDeemph <= lpt_pkg::DEEMPH_3P5;
      link.devTsSpeed  <= 1'b0;
      link.devTsHot    <= 1'b0;
    end else begin
      state         <= next_state;
      laneDown      <= next_lane;
      gen2          <= next_gen2;
      xlink         <= next_xlink;
      negDeemph     <= next_neg;
      deemphApplied <= next_applied;
      holdCnt       <= state == lpt_pkg::ST_HOTRST ? holdCnt + 8'h01
                                                  : 8'h00;
      linkUp        <= next_state == lpt_pkg::ST_L0 ||
                       next_state == lpt_pkg::ST_RECOV;
      portHotReset  <= next_state == lpt_pkg::ST_HOTRST &&
                       portDown;
      partHotReset  <= next_state == lpt_pkg::ST_HOTRST &&
                       !portDown;
      link.devTsValid  <= next_state == lpt_pkg::ST_TRAIN ||
                          next_state == lpt_pkg::ST_RECOV ||
                          next_state == lpt_pkg::ST_HOTRST;
      link.devTsOrient <= portDown;
      link.devTsSeed   <= seed;
      link.devTsDeemph <= deemphSel;
      link.devTsSpeed  <= next_speed;
      link.devTsHot    <= next_state == lpt_pkg::ST_HOTRST;
    end
  end
endmodule

// [lpt_link_if.sv]
// training set exchange between the switch port and its partner
// assumes both ends clocked by the same ref_clk
`timescale 1ns/1ps
interface lpt_link_if;
  // device to partner training set
  logic       devTsValid;
  logic       devTsOrient;
  logic [7:0] devTsSeed;
  logic       devTsDeemph;
  logic       devTsSpeed;
  logic       devTsHot;
  // partner to device training set
  logic       ptnTsValid;
  logic       ptnTsOrient;
  logic [7:0] ptnTsSeed;
  logic       ptnTsDeemph;
  logic       ptnTsSpeed;
  logic       ptnTsHot;

  modport dev (
    output devTsValid, devTsOrient, devTsSeed,
    output devTsDeemph, devTsSpeed, devTsHot,
    input  ptnTsValid, ptnTsOrient, ptnTsSeed,
    input  ptnTsDeemph, ptnTsSpeed, ptnTsHot
  );
  modport ptn (
    input  devTsValid, devTsOrient, devTsSeed,
    input  devTsDeemph, devTsSpeed, devTsHot,
    output ptnTsValid, ptnTsOrient, ptnTsSeed,
    output ptnTsDeemph, ptnTsSpeed, ptnTsHot
  );
endinterface

// [lpt_partner_end.sv]
// link partner training control with plain configuration ports
// assumes synchronous inputs on ref_clk
`timescale 1ns/1ps
module lpt_partner_end (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // configuration
  input  wire logic       cfgDown,
  input  wire logic       cfgDeemph,
  input  wire logic [7:0] cfgSeed,
  input  wire logic       cfgSpeedInit,
  input  wire logic       hotResetReq,
  // link
  lpt_link_if.ptn         link,
  // status
  output logic            laneDown,
  output logic            linkUp,
  output logic            gen2,
  output logic            deemphApplied,
  output logic            inHotReset
);
  lpt_pkg::lpt_state_t state;
  lpt_pkg::lpt_state_t next_state;
  logic [7:0] holdCnt;
  logic       hotPend;
  logic       next_lane;
  logic       next_gen2;
  logic       next_applied;
  logic       next_speed;

  wire rxTs    = link.devTsValid;
  wire rxHot   = rxTs && link.devTsHot;
  wire canHot  = laneDown;
  wire hotDone = holdCnt == lpt_pkg::HOT_HOLD;
  // a downstream-mode switch port keeps its own level, so follow it;
  // an upstream-mode one adopts ours, so apply our own preference
  wire decide  = link.devTsOrient ? link.devTsDeemph : cfgDeemph;

  // training state decisions
  always_comb begin
    next_state   = state;
    next_lane    = laneDown;
    next_gen2    = gen2;
    next_applied = deemphApplied;
    next_speed   = 1'b0;
    case (state)
      lpt_pkg::ST_DETECT: begin
        next_state = lpt_pkg::ST_TRAIN;
      end
      lpt_pkg::ST_TRAIN: begin
        if (rxTs && !link.devTsHot &&
            (link.devTsOrient != cfgDown ||
             link.devTsSeed != cfgSeed)) begin
          next_lane    = link.devTsOrient != cfgDown ? cfgDown
                         : cfgSeed > link.devTsSeed;
          next_gen2    = 1'b0;
          next_applied = lpt_pkg::DEEMPH_3P5;
          next_state   = lpt_pkg::ST_L0;
        end
      end
      lpt_pkg::ST_L0: begin
        if (rxHot) begin
          next_state = lpt_pkg::ST_HOTRST;
        end else if (rxTs || (hotPend && canHot)) begin
          next_state = lpt_pkg::ST_RECOV;
        end else if (!gen2 && cfgSpeedInit) begin
          next_speed = 1'b1;
          next_state = lpt_pkg::ST_RECOV;
        end
      end
      lpt_pkg::ST_RECOV: begin
        next_speed = link.ptnTsSpeed;
        if (rxHot || (rxTs && hotPend && canHot)) begin
          next_state = lpt_pkg::ST_HOTRST;
        end else if (rxTs) begin
          next_gen2  = gen2 || link.ptnTsSpeed || link.devTsSpeed;
          // both ends settle on one level at recovery exit
          next_applied = next_gen2 ? decide
                                   : lpt_pkg::DEEMPH_3P5;
          next_state = lpt_pkg::ST_L0;
        end
      end
      lpt_pkg::ST_HOTRST: begin
        if (hotDone) begin
          next_state = lpt_pkg::ST_DETECT;
        end
      end
      default: begin
        next_state = lpt_pkg::ST_DETECT;
      end
    endcase
  end

  // state, request latch and link outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state            <= lpt_pkg::ST_DETECT;
      laneDown         <= 1'b0;
      gen2             <= 1'b0;
      deemphApplied    <= lpt_pkg::DEEMPH_3P5;
      holdCnt          <= 8'h00;
      hotPend          <= 1'b0;
      linkUp           <= 1'b0;
      inHotReset       <= 1'b0;
      link.ptnTsValid  <= 1'b0;
      link.ptnTsOrient <= 1'b0;
      link.ptnTsSeed   <= 8'h00;
      link.ptnTsDeemph <= lpt_pkg::DEEMPH_3P5;
      link.ptnTsSpeed  <= 1'b0;
      link.ptnTsHot    <= 1'b0;
    end else begin
      state         <= next_state;
      laneDown      <= next_lane;
      gen2          <= next_gen2;
      deemphApplied <= next_applied;
      holdCnt       <= state == lpt_pkg::ST_HOTRST ? holdCnt + 8'h01
                                                  : 8'h00;
      hotPend       <= hotResetReq ||
                       (hotPend && state != lpt_pkg::ST_HOTRST);
      linkUp        <= next_state == lpt_pkg::ST_L0 ||
                       next_state == lpt_pkg::ST_RECOV;
      inHotReset    <= next_state == lpt_pkg::ST_HOTRST;
      link.ptnTsValid  <= next_state == lpt_pkg::ST_TRAIN ||
                          next_state == lpt_pkg::ST_RECOV ||
                          next_state == lpt_pkg::ST_HOTRST;
      link.ptnTsOrient <= cfgDown;
      link.ptnTsSeed   <= cfgSeed;
      link.ptnTsDeemph <= cfgDeemph;
      link.ptnTsSpeed  <= next_speed;
      link.ptnTsHot    <= next_state == lpt_pkg::ST_HOTRST;
    end
  end
endmodule

// [lpt_pkg.sv]
// link training control: shared constants, states and register map
// assumes one 200 MHz clock for both link ends and for the register bus
package lpt_pkg;
  typedef enum logic [2:0] {
    ST_DETECT = 3'b000,
    ST_TRAIN  = 3'b001,
    ST_L0     = 3'b010,
    ST_RECOV  = 3'b011,
    ST_HOTRST = 3'b100
  } lpt_state_t;

  // de-emphasis encoding on the link and in registers
  localparam logic DEEMPH_3P5 = 1'b1;
  localparam logic DEEMPH_6P0 = 1'b0;

  // hot reset hold count: the hot reset state lasts this many cycles plus one
  localparam logic [7:0] HOT_HOLD = 8'h10;

  // register byte offsets
  localparam logic [7:0] OFS_LCTL2  = 8'h00;
  localparam logic [7:0] OFS_PHYCFG = 8'h04;
  localparam logic [7:0] OFS_SEED   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // field positions
  localparam int LC2_DSEL  = 0;
  localparam int CFG_XDIS  = 0;
  localparam int CFG_SPDI  = 1;
  localparam int CFG_DOWN  = 2;
  localparam int CFG_HOTRQ = 3;
  localparam int STS_LANE  = 0;
  localparam int STS_STLSB = 1;
  localparam int STS_GEN2  = 4;
  localparam int STS_DEEMP = 5;
  localparam int STS_XLINK = 6;

  // reset values
  localparam logic       RST_DSEL = 1'b1;
  localparam logic [7:0] RST_SEED = 8'h5A;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HRESP_OKAY    = 2'b00;
endpackage

// [pcie_port_link_training_ctrl_tb.sv]
// testbench: switch port and partner joined over the link interface
// assumes the design package, interface, both ends and lpt_chk
`timescale 1ns/1ps
module pcie_port_link_training_ctrl_tb;
  logic        ref_clk, sys_rst, hsel, hwrite, hready, deemphSel;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic        portHot, partHot, devDe, devUp, pDown, pDe, pSpd;
  logic        pHotReq, pLane, pUp, pGen2, pDeOut, pHot;
  logic [7:0]  pSeed, ds;
  int          n_errors, compares;

  lpt_link_if link ();

  // device end with its register slave
  lpt_device_end u_lpt_device_end (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .link(link), .portHotReset(portHot), .partHotReset(partHot),
    .deemphApplied(devDe), .linkUp(devUp)
  );
  // partner end on plain configuration pins
  lpt_partner_end u_lpt_partner_end (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cfgDown(pDown), .cfgDeemph(pDe),
    .cfgSeed(pSeed), .cfgSpeedInit(pSpd), .hotResetReq(pHotReq),
    .link(link), .laneDown(pLane), .linkUp(pUp), .gen2(pGen2),
    .deemphApplied(pDeOut), .inHotReset(pHot)
  );
  // wire checker beside the interface
  lpt_chk u_lpt_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .devTsValid(link.devTsValid),
    .devTsDeemph(link.devTsDeemph), .devTsHot(link.devTsHot),
    .ptnTsValid(link.ptnTsValid), .ptnTsDeemph(link.ptnTsDeemph),
    .ptnTsHot(link.ptnTsHot)
  );

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // one counted comparison
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // single AHB-Lite word transfer, read data left in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= lpt_pkg::HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", {30'h0000_0000, lpt_pkg::HRESP_OKAY}, {30'h0, hresp});
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdw(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // partner asks for hot reset for one cycle
  task phot();
    @(posedge ref_clk);
    pHotReq <= 1'b1;
    @(posedge ref_clk);
    pHotReq <= 1'b0;
  endtask

  // wait conditions: link up, device hot, partner gen2, partner hot
  function logic cond(input int k);
    case (k)
      0: return (devUp & pUp) === 1'b1;
      1: return (portHot | partHot) === 1'b1;
      2: return pGen2 === 1'b1;
      default: return pHot === 1'b1;
    endcase
  endfunction

  task waitc(input int k);
    for (int i = 0; i < 2000; i++) begin
      @(posedge ref_clk);
      if (cond(k)) break;
    end
    chk("wait", 32'h0000_0001, {31'h0, cond(k)});
  endtask

  task results();
    $display("counts: %0d compares, %0d mismatches", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    results();
  end

  // directed phases with random seeds and preferences
  initial begin
    sys_rst = 1'b1;
    {hsel, hwrite, pSpd, pHotReq, pSeed} = 12'h000;
    {haddr, hwdata} = 64'h0000_0000_0000_0000;
    htrans = 2'h0;
    hsize = 3'h2;
    pDown = 1'b1;
    pDe = 1'b1;
    n_errors = 0;
    compares = 0;
    void'($urandom(49));
    ds = 8'($urandom_range(8'hBF, 8'h40));
    deemphSel = 1'($urandom_range(1, 0));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rdw(lpt_pkg::OFS_LCTL2);
    chk("sde reset", 32'h0000_0001, rd);
    rdw(lpt_pkg::OFS_PHYCFG);
    chk("cfg reset", 32'h0000_0000, rd);
    rdw(lpt_pkg::OFS_SEED);
    chk("seed reset", 32'h0000_005A, rd);
    rdw(8'h10);
    chk("unmapped", 32'h0000_0000, rd);
    wr(lpt_pkg::OFS_SEED, {24'h00_0000, ds});
    wr(lpt_pkg::OFS_LCTL2, {31'h0000_0000, deemphSel});
    rdw(lpt_pkg::OFS_SEED);
    chk("seed", {24'h00_0000, ds}, rd);
    waitc(0);
    rdw(lpt_pkg::OFS_STATUS);
    chk("lanes", 32'h0, rd[lpt_pkg::STS_LANE]);
    chk("xlink", 32'h0, rd[lpt_pkg::STS_XLINK]);
    chk("gen1 rate", 32'h0, rd[lpt_pkg::STS_GEN2]);
    chk("gen1 deemph", 32'h1, devDe);
    wr(lpt_pkg::OFS_PHYCFG, 32'h0000_0008);
    rdw(lpt_pkg::OFS_PHYCFG);
    chk("hot ignored", 32'h0, rd);
    chk("no hot", 32'h0, portHot | partHot);
    phot();
    waitc(1);
    chk("part hot", 32'h1, partHot);
    chk("port hot", 32'h0, portHot);
    pDown <= 1'b0;
    pSeed <= 8'($urandom_range(ds - 8'h01, 0));
    pDe <= ~deemphSel;
    $display("test normal link done");
    waitc(0);
    rdw(lpt_pkg::OFS_STATUS);
    chk("lanes", 32'h1, rd[lpt_pkg::STS_LANE]);
    chk("xlink", 32'h1, rd[lpt_pkg::STS_XLINK]);
    chk("ptn lanes", 32'h0, pLane);
    repeat (64) @(posedge ref_clk);
    chk("gen1 hold", 32'h0, pGen2);
    wr(lpt_pkg::OFS_PHYCFG, 32'h0000_0002);
    waitc(2);
    repeat (2) @(posedge ref_clk);
    chk("dev deemph", {31'h0, pDe}, devDe);
    chk("ptn deemph", {31'h0, pDe}, pDeOut);
    $display("test upstream crosslink done");
    wr(lpt_pkg::OFS_PHYCFG, 32'h0000_0004);
    wr(lpt_pkg::OFS_PHYCFG, 32'h0000_000C);
    waitc(1);
    chk("port hot", 32'h1, portHot);
    chk("part hot", 32'h0, partHot);
    pDown <= 1'b1;
    pSeed <= 8'($urandom_range(255, ds + 8'h01));
    waitc(3);
    rdw(lpt_pkg::OFS_PHYCFG);
    chk("hot clear", 32'h0000_0004, rd);
    waitc(0);
    rdw(lpt_pkg::OFS_STATUS);
    chk("lanes", 32'h0, rd[lpt_pkg::STS_LANE]);
    chk("xlink", 32'h1, rd[lpt_pkg::STS_XLINK]);
    phot();
    waitc(1);
    chk("port hot", 32'h1, portHot);
    chk("part hot", 32'h0, partHot);
    pDown <= 1'b0;
    pDe <= ~deemphSel;
    waitc(0);
    waitc(2);
    repeat (2) @(posedge ref_clk);
    chk("own deemph", {31'h0, deemphSel}, devDe);
    chk("ptn deemph", {31'h0, deemphSel}, pDeOut);
    rdw(lpt_pkg::OFS_STATUS);
    chk("sts deemph", {31'h0, deemphSel}, rd[lpt_pkg::STS_DEEMP]);
    $display("test downstream hot reset done");
    wr(lpt_pkg::OFS_PHYCFG, 32'h0000_000D);
    waitc(1);
    pDown <= 1'b1;
    repeat (100) @(posedge ref_clk);
    chk("no link", 32'h0, devUp);
    wr(lpt_pkg::OFS_PHYCFG, 32'h0000_0004);
    waitc(0);
    rdw(lpt_pkg::OFS_STATUS);
    chk("xlink", 32'h1, rd[lpt_pkg::STS_XLINK]);
    $display("test crosslink disable done");
    results();
  end
endmodule
